// *** pkg/icfe_pkg.sv ***
// constants, types and register map of the input capture front end
// assumes a 32-bit apb master and a 16-bit timer count from outside
package icfe_pkg;

    localparam int NUM_CH = 3;
    localparam int NUM_SOURCES = 9;
    localparam int ADDR_W = 12;
    localparam int DATA_W = 32;
    localparam int FILTER_CYCLES = 4;

    // register indices; byte address is four times the index
    localparam logic [7:0] IDX_CHAN_CTRL = 8'h92;
    localparam logic [7:0] IDX_EDGE_SEL = 8'h93;
    localparam logic [7:0] IDX_FILTER_CTRL = 8'h94;
    localparam logic [7:0] IDX_IRQ_MASK = 8'h95;
    localparam logic [7:0] IDX_RES0_LO = 8'hE4;
    localparam logic [7:0] IDX_RES0_HI = 8'hE5;
    localparam logic [7:0] IDX_RES1_LO = 8'hE6;
    localparam logic [7:0] IDX_RES1_HI = 8'hE7;
    localparam logic [7:0] IDX_RES2_LO = 8'hED;
    localparam logic [7:0] IDX_RES2_HI = 8'hEE;
    localparam logic [7:0] IDX_SRC_SEL = 8'hF1;

    localparam logic [ADDR_W-1:0] ADDR_CHAN_CTRL = {2'h0, IDX_CHAN_CTRL, 2'h0};
    localparam logic [ADDR_W-1:0] ADDR_EDGE_SEL = {2'h0, IDX_EDGE_SEL, 2'h0};
    localparam logic [ADDR_W-1:0] ADDR_FILTER_CTRL =
        {2'h0, IDX_FILTER_CTRL, 2'h0};
    localparam logic [ADDR_W-1:0] ADDR_IRQ_MASK = {2'h0, IDX_IRQ_MASK, 2'h0};
    localparam logic [ADDR_W-1:0] ADDR_SRC_SEL = {2'h0, IDX_SRC_SEL, 2'h0};
    localparam logic [ADDR_W-1:0] ADDR_RES_LO [NUM_CH] = '{
        {2'h0, IDX_RES0_LO, 2'h0}, {2'h0, IDX_RES1_LO, 2'h0},
        {2'h0, IDX_RES2_LO, 2'h0}};
    localparam logic [ADDR_W-1:0] ADDR_RES_HI [NUM_CH] = '{
        {2'h0, IDX_RES0_HI, 2'h0}, {2'h0, IDX_RES1_HI, 2'h0},
        {2'h0, IDX_RES2_HI, 2'h0}};

    // field positions
    localparam int CHAN_EN_LSB = 4;
    localparam int FLAG_LSB = 0;
    localparam int FILTER_EN_LSB = 4;
    localparam int SRC_CH0_LSB = 0;
    localparam int SRC_CH1_LSB = 4;
    localparam int SRC_W = 4;
    localparam int EDGE_W = 2;

    localparam logic [7:0] RESET_BYTE = 8'h00;
    localparam logic [3:0] SRC_FALLBACK = 4'h0;

    typedef enum logic [1:0] {
        EDGE_FALL = 2'h0,
        EDGE_RISE = 2'h1,
        EDGE_ANY = 2'h2,
        EDGE_RSVD = 2'h3
    } icfe_edge_type;

    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [ADDR_W-1:0] paddr;
        logic [DATA_W-1:0] pwdata;
    } icfe_apb_req_type;

    typedef struct packed {
        logic pready;
        logic pslverr;
        logic [DATA_W-1:0] prdata;
    } icfe_apb_rsp_type;

endpackage

// *** hw/icfe_filter.sv ***
// glitch filter for one capture input
// assumes the raw input is already synchronous to clk_i
`timescale 1ns/1ps
module icfe_filter
    import icfe_pkg::*;
#(
    parameter int STABLE = FILTER_CYCLES
) (
    input wire logic clk_i,
    input wire logic arst_n_i,
    input wire logic raw_i,
    input wire logic filter_en_i,
    output logic level_o
);

    logic [STABLE-1:0] hist;

    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            hist <= '0;
        end else begin
            hist <= {hist[STABLE-2:0], raw_i};
        end
    end

    // with filter_en_i set, a level passes only once every stored sample agrees
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            level_o <= 1'b0;
        end else if (!filter_en_i) begin
            level_o <= raw_i;
        end else if (&hist) begin
            level_o <= 1'b1;
        end else if (~|hist) begin
            level_o <= 1'b0;
        end
    end

    a_filter_stable: assert property (@(posedge clk_i)
        disable iff (!arst_n_i)
        (filter_en_i && $changed(level_o)) |->
            ($past(&hist) || $past(~|hist)) || !$past(filter_en_i))
        else $error("filtered level changed without a stable run");

endmodule

// *** hw/icfe_top.sv ***
// input capture front end: source select, filters, edge detect, results
// assumes an apb master on clk_i and a free-running 16-bit timer count
//
// Contract
// - filter enable bits 6,5,4 per channel
// - channel 0 result bytes at E4, E5
// - channel 1 result bytes at E6, E7
// - channel 2 result bytes at ED, EE
// - channel 1 source code in 7:4
// - channel 0 source code in 3:0
// - reset clears filter, results, source select
// - filter drops pulses under four clocks
// - selected edge captures timer, sets flag
// - edge codes: fall, rise, either, reserved
// - disabled channel never captures
`timescale 1ns/1ps
module icfe_top
    import icfe_pkg::*;
(
    input wire logic clk_i,
    input wire logic arst_n_i,
    input wire icfe_apb_req_type apb_i,
    output icfe_apb_rsp_type apb_o,
    input wire logic [NUM_SOURCES-1:0] port_in_i,
    input wire logic [15:0] timer_count_i,
    input wire logic [SRC_W-1:0] source_sel_ch2_i,
    output logic [NUM_CH-1:0] capture_event_o,
    output logic irq_o
);

    logic [7:0] filter_ctrl;
    logic [7:0] source_sel;
    logic [NUM_CH-1:0] channel_en;
    logic [NUM_CH-1:0] capture_flag;
    logic [NUM_CH-1:0] irq_mask;
    logic [EDGE_W*NUM_CH-1:0] edge_sel;
    logic [7:0] res_lo [NUM_CH];
    logic [7:0] res_hi [NUM_CH];
    logic [DATA_W-1:0] prdata_q;
    logic pslverr_q;
    logic [DATA_W-1:0] next_prdata;
    logic next_pslverr;
    logic wr_en;
    logic setup;
    logic [NUM_CH-1:0] event_hit;
    logic [NUM_CH-1:0] src_level;
    logic [NUM_CH-1:0] filt_level;
    logic [NUM_CH-1:0] prev_level;
    logic [SRC_W-1:0] sel_code [NUM_CH];

    assign setup = apb_i.psel && !apb_i.penable;
    assign wr_en = apb_i.psel && apb_i.penable && apb_i.pwrite;

    // no wait states: read data is latched in the setup cycle
    assign apb_o.pready = apb_i.psel && apb_i.penable;
    assign apb_o.prdata = prdata_q;
    assign apb_o.pslverr = pslverr_q;

    always_comb begin
        next_prdata = '0;
        next_pslverr = 1'b0;
        case (apb_i.paddr)
            ADDR_CHAN_CTRL: begin
                next_prdata[CHAN_EN_LSB +: NUM_CH] = channel_en;
                next_prdata[FLAG_LSB +: NUM_CH] = capture_flag;
            end
            ADDR_EDGE_SEL: next_prdata[EDGE_W*NUM_CH-1:0] = edge_sel;
            ADDR_FILTER_CTRL: next_prdata[7:0] = filter_ctrl;
            ADDR_IRQ_MASK: next_prdata[NUM_CH-1:0] = irq_mask;
            ADDR_SRC_SEL: next_prdata[7:0] = source_sel;
            ADDR_RES_LO[0]: next_prdata[7:0] = res_lo[0];
            ADDR_RES_HI[0]: next_prdata[7:0] = res_hi[0];
            ADDR_RES_LO[1]: next_prdata[7:0] = res_lo[1];
            ADDR_RES_HI[1]: next_prdata[7:0] = res_hi[1];
            ADDR_RES_LO[2]: next_prdata[7:0] = res_lo[2];
            ADDR_RES_HI[2]: next_prdata[7:0] = res_hi[2];
            default: next_pslverr = 1'b1;
        endcase
    end

    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            prdata_q <= '0;
            pslverr_q <= 1'b0;
        end else if (setup) begin
            // a write answers with zero so stale read data never leaks out
            prdata_q <= apb_i.pwrite ? '0 : next_prdata;
            pslverr_q <= next_pslverr;
        end
    end

    // only the three enable bits are stored; the rest read as zero
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            filter_ctrl <= RESET_BYTE;
        end else if (wr_en && apb_i.paddr == ADDR_FILTER_CTRL) begin
            filter_ctrl <= '0;
            filter_ctrl[FILTER_EN_LSB +: NUM_CH] <=
                apb_i.pwdata[FILTER_EN_LSB +: NUM_CH];
        end
    end

    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            source_sel <= RESET_BYTE;
        end else if (wr_en && apb_i.paddr == ADDR_SRC_SEL) begin
            source_sel <= apb_i.pwdata[7:0];
        end
    end

    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            channel_en <= '0;
            edge_sel <= '0;
            irq_mask <= '0;
        end else if (wr_en) begin
            if (apb_i.paddr == ADDR_CHAN_CTRL) begin
                channel_en <= apb_i.pwdata[CHAN_EN_LSB +: NUM_CH];
            end
            if (apb_i.paddr == ADDR_EDGE_SEL) begin
                edge_sel <= apb_i.pwdata[EDGE_W*NUM_CH-1:0];
            end
            if (apb_i.paddr == ADDR_IRQ_MASK) begin
                irq_mask <= apb_i.pwdata[NUM_CH-1:0];
            end
        end
    end

    // write one to clear; a capture in the same cycle keeps the flag set
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            capture_flag <= '0;
        end else begin
            capture_flag <= (capture_flag & ~((wr_en &&
                apb_i.paddr == ADDR_CHAN_CTRL) ?
                apb_i.pwdata[FLAG_LSB +: NUM_CH] : '0)) | event_hit;
        end
    end

    assign irq_o = |(capture_flag & irq_mask);
    assign capture_event_o = event_hit;

    assign sel_code[0] = source_sel[SRC_CH0_LSB +: SRC_W];
    assign sel_code[1] = source_sel[SRC_CH1_LSB +: SRC_W];
    assign sel_code[2] = source_sel_ch2_i;

    genvar ch;
    generate
        for (ch = 0; ch < NUM_CH; ch++) begin : g_ch
            logic [1:0] mode;
            logic rise;
            logic fall;

            // codes past the last source fall back to code zero
            assign src_level[ch] =
                (sel_code[ch] < SRC_W'(NUM_SOURCES)) ?
                port_in_i[sel_code[ch]] : port_in_i[SRC_FALLBACK];

            icfe_filter #(.STABLE(FILTER_CYCLES)) u_filter (
                .clk_i(clk_i),
                .arst_n_i(arst_n_i),
                .raw_i(src_level[ch]),
                .filter_en_i(filter_ctrl[FILTER_EN_LSB + ch]),
                .level_o(filt_level[ch])
            );

            // prev tracks even while disabled, so enabling never fakes an edge
            always_ff @(posedge clk_i or negedge arst_n_i) begin
                if (!arst_n_i) begin
                    prev_level[ch] <= 1'b0;
                end else begin
                    prev_level[ch] <= filt_level[ch];
                end
            end

            assign mode = edge_sel[EDGE_W*ch +: EDGE_W];
            assign rise = filt_level[ch] && !prev_level[ch];
            assign fall = !filt_level[ch] && prev_level[ch];

            always_comb begin
                event_hit[ch] = 1'b0;
                if (channel_en[ch]) begin
                    case (mode)
                        EDGE_FALL: event_hit[ch] = fall;
                        EDGE_RISE: event_hit[ch] = rise;
                        EDGE_ANY: event_hit[ch] = rise || fall;
                        default: event_hit[ch] = 1'b0;
                    endcase
                end
            end

            // capture beats a software write landing in the same cycle
            always_ff @(posedge clk_i or negedge arst_n_i) begin
                if (!arst_n_i) begin
                    res_lo[ch] <= RESET_BYTE;
                    res_hi[ch] <= RESET_BYTE;
                end else if (event_hit[ch]) begin
                    res_lo[ch] <= timer_count_i[7:0];
                    res_hi[ch] <= timer_count_i[15:8];
                end else if (wr_en) begin
                    if (apb_i.paddr == ADDR_RES_LO[ch]) begin
                        res_lo[ch] <= apb_i.pwdata[7:0];
                    end
                    if (apb_i.paddr == ADDR_RES_HI[ch]) begin
                        res_hi[ch] <= apb_i.pwdata[7:0];
                    end
                end
            end

            a_capture_loads_count: assert property (@(posedge clk_i)
                disable iff (!arst_n_i)
                event_hit[ch] |=>
                    {res_hi[ch], res_lo[ch]} == $past(timer_count_i))
                else $error("capture result does not match timer count");

            a_flag_follows_event: assert property (@(posedge clk_i)
                disable iff (!arst_n_i)
                event_hit[ch] |=> capture_flag[ch])
                else $error("capture flag not set after event");

            a_flag_holds: assert property (@(posedge clk_i)
                disable iff (!arst_n_i)
                (capture_flag[ch] && !(wr_en &&
                    apb_i.paddr == ADDR_CHAN_CTRL &&
                    apb_i.pwdata[FLAG_LSB + ch])) |=> capture_flag[ch])
                else $error("capture flag dropped without a clear");

            a_disabled_no_event: assert property (@(posedge clk_i)
                disable iff (!arst_n_i)
                !channel_en[ch] |-> !event_hit[ch])
                else $error("disabled channel produced an event");

            a_edge_polarity: assert property (@(posedge clk_i)
                disable iff (!arst_n_i)
                event_hit[ch] |->
                    (mode == EDGE_FALL && !filt_level[ch] &&
                        $past(filt_level[ch])) ||
                    (mode == EDGE_RISE && filt_level[ch] &&
                        !$past(filt_level[ch])) ||
                    (mode == EDGE_ANY && $changed(filt_level[ch])))
                else $error("event on the wrong edge");

            a_reserved_silent: assert property (@(posedge clk_i)
                disable iff (!arst_n_i)
                mode == EDGE_RSVD |-> !event_hit[ch])
                else $error("reserved edge code produced an event");

            a_bypass_follows: assert property (@(posedge clk_i)
                disable iff (!arst_n_i)
                (!filter_ctrl[FILTER_EN_LSB + ch] &&
                    !$past(filter_ctrl[FILTER_EN_LSB + ch])) |->
                    filt_level[ch] == $past(src_level[ch]))
                else $error("bypassed filter did not pass the input");

            a_short_pulse_dropped: assert property (@(posedge clk_i)
                disable iff (!arst_n_i)
                // three high samples is the longest pulse that must die
                (filter_ctrl[FILTER_EN_LSB + ch] && !filt_level[ch] &&
                    $rose(src_level[ch])) ##1
                    (filter_ctrl[FILTER_EN_LSB + ch] && src_level[ch]) ##1
                    (filter_ctrl[FILTER_EN_LSB + ch] && src_level[ch]) ##1
                    (filter_ctrl[FILTER_EN_LSB + ch] && !src_level[ch]) |->
                    ##1 !filt_level[ch] ##1 !filt_level[ch])
                else $error("three-cycle glitch reached the edge detector");

            c_capture_seen: cover property (@(posedge clk_i)
                disable iff (!arst_n_i) event_hit[ch]);
        end
    endgenerate

    a_source_fallback: assert property (@(posedge clk_i)
        disable iff (!arst_n_i)
        sel_code[1] > 4'h8 |-> src_level[1] == port_in_i[SRC_FALLBACK])
        else $error("unlisted source code did not fall back");

    a_ch0_source: assert property (@(posedge clk_i)
        disable iff (!arst_n_i)
        sel_code[0] <= 4'h8 |-> src_level[0] == port_in_i[sel_code[0]])
        else $error("channel 0 picked the wrong source");

    a_filter_reserved_zero: assert property (@(posedge clk_i)
        disable iff (!arst_n_i)
        filter_ctrl[7] == 1'b0 && filter_ctrl[3:0] == 4'h0)
        else $error("unused filter control bits are set");

    a_read_result: assert property (@(posedge clk_i)
        disable iff (!arst_n_i)
        (setup && !apb_i.pwrite && apb_i.paddr == ADDR_RES_HI[0]) |=>
            prdata_q == {24'h0, $past(res_hi[0])})
        else $error("channel 0 high byte read back wrong");

    a_irq_from_flag: assert property (@(posedge clk_i)
        disable iff (!arst_n_i)
        (event_hit[0] && irq_mask[0]) |=> irq_o)
        else $error("masked-in capture did not raise the interrupt");

    c_irq_raised: cover property (@(posedge clk_i)
        disable iff (!arst_n_i) $rose(irq_o));

    c_any_edge: cover property (@(posedge clk_i)
        disable iff (!arst_n_i)
        event_hit[1] && edge_sel[3:2] == EDGE_ANY && !filt_level[1]);

    c_filtered_capture: cover property (@(posedge clk_i)
        disable iff (!arst_n_i)
        event_hit[0] && filter_ctrl[FILTER_EN_LSB]);

    c_short_pulse: cover property (@(posedge clk_i)
        disable iff (!arst_n_i)
        filter_ctrl[FILTER_EN_LSB + 2] && $fell(src_level[2]) &&
            !filt_level[2]);

endmodule

// *** testbench/icfe_pins_model.sv ***
// model of the external pins that feed the nine capture sources
// assumes clk_i is the design clock; pins move just after its edge
`timescale 1ns/1ps
module icfe_pins_model
    import icfe_pkg::*;
(
    input wire logic clk_i,
    output logic [NUM_SOURCES-1:0] port_o
);
    initial port_o = '0;

    // pins change right after an edge so the design samples a settled level
    task automatic set_pin(input int idx, input logic lvl);
        @(posedge clk_i);
        port_o[idx] <= lvl;
    endtask

    // a pin held inverted for width cycles, then restored
    task automatic pulse(input int idx, input int width);
        set_pin(idx, ~port_o[idx]);
        repeat (width) @(posedge clk_i);
        port_o[idx] <= ~port_o[idx];
    endtask
endmodule

// *** testbench/testbench.sv ***
// self-checking bench for the input capture front end
// assumes zero or more apb wait states and a bench-made timer count
`timescale 1ns/1ps
`define CHK(got, exp, msg) \
    begin n_tests++; if ((got) !== (exp)) begin err_total++; \
    $display("MISMATCH %0t %s got %0h exp %0h", $time, msg, got, exp); end end
module testbench
    import icfe_pkg::*;
;
    // distinct byte steps so a swapped high and low byte shows up
    localparam logic [15:0] TMR_STEP = 16'h0107;
    localparam logic [ADDR_W-1:0] RST_LIST [8] = '{ADDR_FILTER_CTRL,
        ADDR_SRC_SEL, ADDR_RES_LO[0], ADDR_RES_HI[0], ADDR_RES_LO[1],
        ADDR_RES_HI[1], ADDR_RES_LO[2], ADDR_RES_HI[2]};
    logic clk_i;
    logic arst_n_i;
    icfe_apb_req_type req;
    icfe_apb_rsp_type rsp;
    logic [NUM_SOURCES-1:0] port_w;
    logic [15:0] timer;
    logic [SRC_W-1:0] src2;
    logic [NUM_CH-1:0] cap_ev;
    logic irq;
    int err_total;
    int n_tests;
    logic [15:0] last [NUM_CH];
    logic [7:0] en_bits;
    logic [7:0] mask_bits;
    logic [31:0] rd;
    logic err;

    icfe_top icfe_top_inst (.clk_i(clk_i), .arst_n_i(arst_n_i), .apb_i(req),
        .apb_o(rsp), .port_in_i(port_w), .timer_count_i(timer),
        .source_sel_ch2_i(src2), .capture_event_o(cap_ev), .irq_o(irq));
    icfe_pins_model icfe_pins_model_inst (.clk_i(clk_i), .port_o(port_w));

    initial begin
        clk_i = 1'b0;
        forever #50 clk_i = ~clk_i;
    end

    always @(posedge clk_i) begin
        timer <= timer + TMR_STEP;
    end

    task automatic wrap_up;
        $display("checks %0d mismatches %0d", n_tests, err_total);
        if (err_total == 0 && n_tests > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    task automatic xfer(input logic w, input logic [ADDR_W-1:0] a,
                        input logic [7:0] d);
        int n;
        n = 0;
        @(posedge clk_i);
        req <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a,
                 pwdata: {24'h0, d}};
        @(posedge clk_i);
        req.penable <= 1'b1;
        do begin
            @(posedge clk_i);
            n++;
        end while (rsp.pready !== 1'b1 && n < 16);
        rd = rsp.prdata;
        err = rsp.pslverr;
        req.psel <= 1'b0;
        req.penable <= 1'b0;
        if (n >= 16) begin
            err_total++;
            $display("MISMATCH %0t no pready", $time);
        end
    endtask

    // move one pin, then check result bytes, flag and irq of a channel
    task automatic toggle(input int ch, input int pin, input logic lvl,
                          input int k, input bit hit);
        logic [15:0] t0;
        logic [15:0] exp;
        logic [7:0] lo;
        icfe_pins_model_inst.set_pin(pin, lvl);
        #1 t0 = timer;
        // the event pulse stands for one cycle, k edges after the pin moved
        repeat (k) @(posedge clk_i);
        #1;
        `CHK(cap_ev[ch], hit, "event")
        @(posedge clk_i);
        #1;
        `CHK(cap_ev[ch], 1'b0, "event one cycle")
        repeat (10) @(posedge clk_i);
        exp = hit ? t0 + 16'(k) * TMR_STEP : last[ch];
        xfer(1'b0, ADDR_RES_LO[ch], 8'h00);
        lo = rd[7:0];
        xfer(1'b0, ADDR_RES_HI[ch], 8'h00);
        `CHK({rd[7:0], lo}, exp, "result")
        last[ch] = exp;
        xfer(1'b0, ADDR_CHAN_CTRL, 8'h00);
        `CHK(rd[FLAG_LSB + ch], hit, "flag")
        `CHK(irq, hit & mask_bits[ch], "irq")
        xfer(1'b1, ADDR_CHAN_CTRL, en_bits | (8'h01 << ch));
        #1;
        `CHK(irq, 1'b0, "irq clear")
    endtask

    initial begin
        repeat (30000) @(posedge clk_i);
        err_total++;
        $display("MISMATCH %0t watchdog expired", $time);
        wrap_up();
    end

    initial begin
        req = '0;
        src2 = 4'h0;
        timer = 16'h0000;
        arst_n_i = 1'b0;
        err_total = 0;
        n_tests = 0;
        last = '{16'h0000, 16'h0000, 16'h0000};
        repeat (4) @(posedge clk_i);
        arst_n_i <= 1'b1;
        foreach (RST_LIST[i]) begin
            xfer(1'b0, RST_LIST[i], 8'h00);
            `CHK(rd, 32'h0, "reset value")
            `CHK(err, 1'b0, "mapped")
        end
        xfer(1'b1, ADDR_FILTER_CTRL, 8'hFF);
        xfer(1'b0, ADDR_FILTER_CTRL, 8'h00);
        `CHK(rd, 32'h70, "filter bits")
        xfer(1'b1, ADDR_FILTER_CTRL, 8'h00);
        xfer(1'b0, 12'h004, 8'h00);
        `CHK(err, 1'b1, "unmapped")
        xfer(1'b1, ADDR_RES_HI[1], 8'h5A);
        xfer(1'b0, ADDR_RES_HI[1], 8'h00);
        `CHK(rd, 32'h5A, "result write")
        last[1] = 16'h5A00;
        $display("test registers done");
        mask_bits = 8'h07;
        xfer(1'b1, ADDR_IRQ_MASK, mask_bits);
        for (int ch = 0; ch < 2; ch++) begin
            en_bits = 8'h10 << ch;
            xfer(1'b1, ADDR_CHAN_CTRL, en_bits);
            xfer(1'b1, ADDR_EDGE_SEL, 8'h01 << (2 * ch));
            for (int c = 0; c < 16; c++) begin
                xfer(1'b1, ADDR_SRC_SEL, 8'(c << (4 * ch)));
                toggle(ch, (c > 8) ? 0 : c, 1'b1, 1, 1'b1);
                toggle(ch, (c > 8) ? 0 : c, 1'b0, 1, 1'b0);
            end
        end
        $display("test source select done");
        xfer(1'b1, ADDR_SRC_SEL, 8'h30);
        for (int e = 0; e < 4; e++) begin
            xfer(1'b1, ADDR_EDGE_SEL, 8'(e << 2));
            toggle(1, 3, 1'b1, 1, e == 1 || e == 2);
            toggle(1, 3, 1'b0, 1, e == 0 || e == 2);
        end
        $display("test edge codes done");
        @(posedge clk_i);
        src2 <= 4'h2;
        en_bits = 8'h00;
        xfer(1'b1, ADDR_CHAN_CTRL, en_bits);
        xfer(1'b1, ADDR_EDGE_SEL, 8'h20);
        toggle(2, 2, 1'b1, 1, 1'b0);
        toggle(2, 2, 1'b0, 1, 1'b0);
        en_bits = 8'h40;
        xfer(1'b1, ADDR_CHAN_CTRL, en_bits);
        toggle(2, 2, 1'b1, 1, 1'b1);
        toggle(2, 2, 1'b0, 1, 1'b1);
        $display("test channel enable done");
        xfer(1'b1, ADDR_FILTER_CTRL, 8'h40);
        icfe_pins_model_inst.pulse(2, 3);
        repeat (12) @(posedge clk_i);
        xfer(1'b0, ADDR_CHAN_CTRL, 8'h00);
        `CHK(rd[2], 1'b0, "short pulse")
        icfe_pins_model_inst.pulse(2, 4);
        repeat (12) @(posedge clk_i);
        xfer(1'b0, ADDR_CHAN_CTRL, 8'h00);
        `CHK(rd[2], 1'b1, "four cycle pulse")
        xfer(1'b1, ADDR_CHAN_CTRL, 8'h44);
        toggle(2, 2, 1'b1, 5, 1'b1);
        toggle(2, 2, 1'b0, 5, 1'b1);
        $display("test filter done");
        wrap_up();
    end
endmodule
